/* include/umc_defs.svh */
// Constants for the modem-control, modem-status and baud generator block.
// Assumes the includer needs only these macros; no logic lives here.
`ifndef UMC_DEFS_SVH
`define UMC_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets on the three-bit register address
// ----------------------------------------------------------------------
`define UMC_OFF_DIV_LO     3'h0
`define UMC_OFF_DIV_HI     3'h1
`define UMC_OFF_MCTL       3'h4
`define UMC_OFF_MSTAT      3'h6

// ----------------------------------------------------------------------
// Modem-control field positions
// ----------------------------------------------------------------------
`define UMC_MCTL_TERM_RDY  0
`define UMC_MCTL_REQ_SEND  1
`define UMC_MCTL_AUX_ONE   2
`define UMC_MCTL_IRQ_EN    3
`define UMC_MCTL_LOOP      4
`define UMC_MCTL_WIDTH     5

// ----------------------------------------------------------------------
// Modem-status field positions (change bits 0..3, levels 4..7)
// ----------------------------------------------------------------------
`define UMC_MS_CTS         0
`define UMC_MS_DSR         1
`define UMC_MS_RING        2
`define UMC_MS_DCD         3
`define UMC_MS_LVL_LSB     4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UMC_MCTL_RST       5'h00
`define UMC_DELTA_RST      4'h0
`define UMC_DIV_RST        16'h0000

`endif

/* include/umc_pkg.sv */
// Types used by the modem-control file; the baud generator file uses none.
// Assumes umc_defs.svh supplies the numeric constants.
package umc_pkg;

   // Data byte on the register port
   typedef logic [7:0] umc_byte_t;

   // Decoded register selection
   typedef enum logic [2:0]
   {
      UMC_SEL_NONE  = 3'b000,
      UMC_SEL_MCTL  = 3'b001,
      UMC_SEL_MSTAT = 3'b010,
      UMC_SEL_DIVLO = 3'b011,
      UMC_SEL_DIVHI = 3'b100
   } umc_reg_sel_t;

endpackage

/* rtl/umc_baud_gen.sv */
// Baud generator: down counter producing a 16x sample enable pulse.
// Assumes the divisor and a reload pulse come from the register logic.
`timescale 1ns/1ns
`include "umc_defs.svh"

module umc_baud_gen #(
   parameter int DIV_W = 16                    // Divisor width
)(
   input  wire logic             i_clk,        // Reference clock
   input  wire logic             i_reset_n,    // Synchronous reset
   input  wire logic [DIV_W-1:0] i_divisor,    // Current divisor
   input  wire logic             i_reload,     // Divisor latch written
   output logic                  o_tick        // 16x sample enable
);

   logic [DIV_W-1:0] cnt_q;                    // Count remaining
   logic [DIV_W-1:0] cnt_d;
   logic             tick_q;                   // Registered pulse
   logic             tick_d;

   // ------------------------------------------------------------------
   // Next count and pulse
   // ------------------------------------------------------------------
   always_comb
   begin
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (i_reload)
      begin
         // New divisor takes effect at once
         cnt_d = i_divisor;
      end
      else if (i_divisor == '0)
      begin
         // Zero divisor: generator idle
         cnt_d = '0;
      end
      else if (cnt_q <= DIV_W'(1))
      begin
         // Terminal count: reload and pulse once
         cnt_d  = i_divisor;
         tick_d = 1'b1;
      end
      else
      begin
         // One step down per reference clock
         cnt_d = cnt_q - DIV_W'(1);
      end
   end

   // Register stage
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         cnt_q  <= DIV_W'(`UMC_DIV_RST);
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign o_tick = tick_q;

endmodule

/* rtl/umc_delta_detect.sv */
// Change detection for the four modem-status indicators.
// Assumes status levels are synchronous and a read window is flagged.
`timescale 1ns/1ns
`include "umc_defs.svh"

module umc_delta_detect (
   input  wire logic       i_clk,          // Reference clock
   input  wire logic       i_reset_n,      // Synchronous reset
   input  wire logic [3:0] i_level,        // CTS, DSR, ring, DCD levels
   input  wire logic       i_read_active,  // Status read in progress
   input  wire logic       i_read_end,     // Trailing edge of that read
   output logic      [3:0] o_delta         // Change indicators
);

   logic [3:0] prev_q;                     // Levels one cycle back
   logic [3:0] prev_d;
   logic [3:0] delta_q;                    // Visible change bits
   logic [3:0] delta_d;
   logic [3:0] pend_q;                     // Events held during a read
   logic [3:0] pend_d;
   logic [3:0] ev;                         // Events this cycle

   // ------------------------------------------------------------------
   // Event detection and read deferral
   // ------------------------------------------------------------------
   always_comb
   begin
      ev = i_level ^ prev_q;
      // Ring counts only its trailing edge: status falls as pin rises
      ev[`UMC_MS_RING] = prev_q[`UMC_MS_RING] & ~i_level[`UMC_MS_RING];
      prev_d  = i_level;
      delta_d = delta_q;
      pend_d  = pend_q;
      if (i_read_end)
      begin
         // Read clears; set bits that saw a repeat stay cleared
         delta_d = (pend_q | ev) & ~delta_q;
         pend_d  = 4'h0;
      end
      else if (i_read_active)
      begin
         // Hold new events until the read ends
         pend_d = pend_q | ev;
      end
      else
      begin
         // Normal sticky set
         delta_d = delta_q | ev;
      end
   end

   // Register stage; levels are captured on reset to avoid false events
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         prev_q  <= i_level;
         delta_q <= `UMC_DELTA_RST;
         pend_q  <= 4'h0;
      end
      else
      begin
         prev_q  <= prev_d;
         delta_q <= delta_d;
         pend_q  <= pend_d;
      end
   end

   assign o_delta = delta_q;

endmodule

/* rtl/umc_modem_ctrl.sv */
// Modem control, modem status, loopback and baud generator for one channel.
// Assumes a parallel register port with one-cycle write and level read
// strobes, pins synchronous to i_clk, and the line-control divisor
// access bit supplied from the line control logic.
`timescale 1ns/1ns
`include "umc_defs.svh"

module umc_modem_ctrl #(
   parameter int DIV_W = 16                      // Baud divisor width
)(
   input  wire logic       i_clk,                // Reference clock, 20 MHz
   input  wire logic       i_reset_n,            // Synchronous reset
   input  wire logic [2:0] i_addr,               // Register address
   input  wire logic       i_write_strobe,       // One-cycle write
   input  wire logic [7:0] i_write_data,         // Write data
   input  wire logic       i_read_strobe,        // Read held as a level
   input  wire logic       i_divisor_access_bit, // Line control bit 7
   input  wire logic       i_clear_to_send_n,    // Handshake input
   input  wire logic       i_data_set_ready_n,   // Handshake input
   input  wire logic       i_ring_in_pin_n,      // Ring input
   input  wire logic       i_carrier_detect_in_n,// Carrier input
   input  wire logic       i_serial_in_pin,      // Serial line input
   input  wire logic       i_tx_shift_reg_out,   // Transmit shift output
   input  wire logic       i_chan_irq_req,       // Channel interrupt request
   input  wire logic       i_ms_irq_enable,      // Status interrupt enable
   output logic      [7:0] o_read_data,          // Read data
   output logic            o_terminal_ready_n,   // Handshake output
   output logic            o_request_to_send_n,  // Handshake output
   output logic            o_serial_out_pin,     // Serial line output
   output logic            o_rx_shift_reg_in,    // Receive shift input
   output logic            o_ext_irq,            // External interrupt pin
   output logic            o_ms_irq_req,         // Status interrupt to priority logic
   output logic            o_loopback,           // Loopback mode active
   output logic            o_sample_enable       // 16x sample enable
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [`UMC_MCTL_WIDTH-1:0] mctl_q;           // Modem-control bits 0..4
   logic [`UMC_MCTL_WIDTH-1:0] mctl_d;
   logic [7:0]                 div_lo_q;         // Divisor low byte
   logic [7:0]                 div_lo_d;
   logic [7:0]                 div_hi_q;         // Divisor high byte
   logic [7:0]                 div_hi_d;
   logic                       reload_q;         // Baud counter reload
   logic                       reload_d;
   logic                       rd_ms_q;          // Status read seen last cycle
   logic                       rd_ms_now;        // Status read this cycle
   logic                       rd_ms_end;        // Trailing edge of status read
   logic [3:0]                 level;            // Effective status levels
   logic [3:0]                 delta;            // Change indicators
   logic                       tick;             // Baud generator pulse
   umc_pkg::umc_reg_sel_t      sel;              // Decoded address
   umc_pkg::umc_byte_t         rdata_d;          // Next read data
   umc_pkg::umc_byte_t         rdata_q;
   logic                       dtr_n_d;          // Next pin values
   logic                       dtr_n_q;
   logic                       rts_n_d;
   logic                       rts_n_q;
   logic                       serial_out_pin_d;
   logic                       serial_out_pin_q;
   logic                       rxin_d;
   logic                       rxin_q;
   logic                       ext_irq_d;
   logic                       ext_irq_q;
   logic                       ms_irq_d;
   logic                       ms_irq_q;
   logic                       loop_q;

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------

   // Map an address to a register; divisor slots need the access bit
   function automatic umc_pkg::umc_reg_sel_t decode(input logic [2:0] addr,
                                                    input logic       dab);
      umc_pkg::umc_reg_sel_t s;
      s = umc_pkg::UMC_SEL_NONE;
      if (addr == `UMC_OFF_MCTL)
         s = umc_pkg::UMC_SEL_MCTL;
      else if (addr == `UMC_OFF_MSTAT)
         s = umc_pkg::UMC_SEL_MSTAT;
      else if (dab && addr == `UMC_OFF_DIV_LO)
         s = umc_pkg::UMC_SEL_DIVLO;
      else if (dab && addr == `UMC_OFF_DIV_HI)
         s = umc_pkg::UMC_SEL_DIVHI;
      return s;
   endfunction

   // Decoded register for the current access
   assign sel = decode(i_addr, i_divisor_access_bit);

   // ------------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------------

   // Next control and divisor values
   always_comb
   begin
      mctl_d   = mctl_q;
      div_lo_d = div_lo_q;
      div_hi_d = div_hi_q;
      reload_d = 1'b0;
      if (i_write_strobe)
      begin
         unique case (sel)
            umc_pkg::UMC_SEL_MCTL:
            begin
               // Only five bits are kept; bit 2 is stored as is
               mctl_d = i_write_data[`UMC_MCTL_WIDTH-1:0];
            end
            umc_pkg::UMC_SEL_DIVLO:
            begin
               // Low byte, counter reloads next cycle
               div_lo_d = i_write_data;
               reload_d = 1'b1;
            end
            umc_pkg::UMC_SEL_DIVHI:
            begin
               // High byte, counter reloads next cycle
               div_hi_d = i_write_data;
               reload_d = 1'b1;
            end
            umc_pkg::UMC_SEL_MSTAT,
            umc_pkg::UMC_SEL_NONE:
            begin
               // Status is read only; other addresses not ours
               mctl_d = mctl_q;
            end
         endcase
      end
   end

   // Control registers
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         mctl_q   <= `UMC_MCTL_RST;
         // Both divisor bytes cleared together
         {div_hi_q, div_lo_q} <= `UMC_DIV_RST;
         reload_q <= 1'b0;
      end
      else
      begin
         mctl_q   <= mctl_d;
         div_lo_q <= div_lo_d;
         div_hi_q <= div_hi_d;
         reload_q <= reload_d;
      end
   end

   // ------------------------------------------------------------------
   // Modem status levels
   // ------------------------------------------------------------------

   // Loopback swaps pins for control bits
   always_comb
   begin
      if (mctl_q[`UMC_MCTL_LOOP])
      begin
         // Control bits replace the pins
         level[`UMC_MS_CTS]  = mctl_q[`UMC_MCTL_REQ_SEND];
         level[`UMC_MS_DSR]  = mctl_q[`UMC_MCTL_TERM_RDY];
         level[`UMC_MS_RING] = mctl_q[`UMC_MCTL_AUX_ONE];
         level[`UMC_MS_DCD]  = mctl_q[`UMC_MCTL_IRQ_EN];
      end
      else
      begin
         // A one means the pin is low
         level[`UMC_MS_CTS]  = ~i_clear_to_send_n;
         level[`UMC_MS_DSR]  = ~i_data_set_ready_n;
         level[`UMC_MS_RING] = ~i_ring_in_pin_n;
         level[`UMC_MS_DCD]  = ~i_carrier_detect_in_n;
      end
   end

   // Status read window, tracked for its trailing edge
   assign rd_ms_now = i_read_strobe && (sel == umc_pkg::UMC_SEL_MSTAT);
   assign rd_ms_end = rd_ms_q && !rd_ms_now;

   // Change bits with read deferral
   umc_delta_detect u_delta (
      .i_clk         (i_clk),
      .i_reset_n     (i_reset_n),
      .i_level       (level),
      .i_read_active (rd_ms_now),
      .i_read_end    (rd_ms_end),
      .o_delta       (delta)
   );

   // ------------------------------------------------------------------
   // Baud generator
   // ------------------------------------------------------------------

   // Divisor formed from both latches
   umc_baud_gen #(
      .DIV_W (DIV_W)
   ) u_baud (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_divisor (DIV_W'({div_hi_q, div_lo_q})),
      .i_reload  (reload_q),
      .o_tick    (tick)
   );

   // ------------------------------------------------------------------
   // Read data and pin outputs
   // ------------------------------------------------------------------

   // Next read data and pin levels
   always_comb
   begin
      rdata_d = 8'h00;
      if (i_read_strobe)
      begin
         unique case (sel)
            umc_pkg::UMC_SEL_MCTL:
               rdata_d = {3'h0, mctl_q};
            umc_pkg::UMC_SEL_MSTAT:
               rdata_d = {level, delta};
            umc_pkg::UMC_SEL_DIVLO:
               rdata_d = div_lo_q;
            umc_pkg::UMC_SEL_DIVHI:
               rdata_d = div_hi_q;
            umc_pkg::UMC_SEL_NONE:
               rdata_d = 8'h00;
         endcase
      end
      if (mctl_q[`UMC_MCTL_LOOP])
      begin
         // Handshake outputs inactive, line at mark, data looped
         dtr_n_d = 1'b1;
         rts_n_d = 1'b1;
         serial_out_pin_d  = 1'b1;
         rxin_d  = i_tx_shift_reg_out;
      end
      else
      begin
         // Set control bit drives the pin low
         dtr_n_d = ~mctl_q[`UMC_MCTL_TERM_RDY];
         rts_n_d = ~mctl_q[`UMC_MCTL_REQ_SEND];
         serial_out_pin_d  = i_tx_shift_reg_out;
         rxin_d  = i_serial_in_pin;
      end
      // Interrupts run in both modes
      ext_irq_d = i_chan_irq_req & mctl_q[`UMC_MCTL_IRQ_EN];
      ms_irq_d  = i_ms_irq_enable & (|delta);
   end

   // Output registers
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         rdata_q   <= 8'h00;
         dtr_n_q   <= 1'b1;
         rts_n_q   <= 1'b1;
         serial_out_pin_q    <= 1'b1;
         rxin_q    <= 1'b1;
         ext_irq_q <= 1'b0;
         ms_irq_q  <= 1'b0;
         loop_q    <= 1'b0;
         rd_ms_q   <= 1'b0;
      end
      else
      begin
         rdata_q   <= rdata_d;
         dtr_n_q   <= dtr_n_d;
         rts_n_q   <= rts_n_d;
         serial_out_pin_q    <= serial_out_pin_d;
         rxin_q    <= rxin_d;
         ext_irq_q <= ext_irq_d;
         ms_irq_q  <= ms_irq_d;
         loop_q    <= mctl_q[`UMC_MCTL_LOOP];
         rd_ms_q   <= rd_ms_now;
      end
   end

   // Outputs straight from flip-flops
   assign o_read_data         = rdata_q;
   assign o_terminal_ready_n  = dtr_n_q;
   assign o_request_to_send_n = rts_n_q;
   assign o_serial_out_pin    = serial_out_pin_q;
   assign o_rx_shift_reg_in   = rxin_q;
   assign o_ext_irq           = ext_irq_q;
   assign o_ms_irq_req        = ms_irq_q;
   assign o_loopback          = loop_q;
   assign o_sample_enable     = tick;

endmodule

/* test/umc_modem_ctrl_asserts.sv */
// Port checker for the modem control block.
// Bound to umc_modem_ctrl from the bench top; one clock domain.
`timescale 1ns/1ns
module umc_modem_ctrl_asserts #(
   parameter int DIV_W = 16
)(
   input wire logic       i_clk,
   input wire logic       i_reset_n,
   input wire logic [2:0] i_addr,
   input wire logic       i_write_strobe,
   input wire logic [7:0] i_write_data,
   input wire logic       i_read_strobe,
   input wire logic       i_tx_shift_reg_out,
   input wire logic       i_chan_irq_req,
   input wire logic       i_ms_irq_enable,
   input wire logic [7:0] o_read_data,
   input wire logic       o_terminal_ready_n,
   input wire logic       o_request_to_send_n,
   input wire logic       o_serial_out_pin,
   input wire logic       o_rx_shift_reg_in,
   input wire logic       o_ext_irq,
   input wire logic       o_ms_irq_req,
   input wire logic       o_loopback
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // Control write followed by a quiet cycle
   sequence ctrl_wr;
      i_write_strobe && i_addr == 3'h4 ##1 !i_write_strobe;
   endsequence
   // Loopback settled for two cycles
   sequence loop_held;
      o_loopback && $past(o_loopback);
   endsequence
   term_rdy_drive_a: assert property (ctrl_wr |-> ##1
      o_terminal_ready_n == ($past(i_write_data[4], 2) | !$past(i_write_data[0], 2)))
      else $error("terminal ready pin wrong after control write");
   req_send_drive_a: assert property (ctrl_wr |-> ##1
      o_request_to_send_n == ($past(i_write_data[4], 2) | !$past(i_write_data[1], 2)))
      else $error("request to send pin wrong after control write");
   loop_flag_a: assert property (ctrl_wr |-> ##1 o_loopback == $past(i_write_data[4], 2))
      else $error("loopback flag wrong after control write");
   tx_mark_a: assert property (loop_held |-> o_serial_out_pin)
      else $error("serial out not at mark in loopback");
   loop_data_a: assert property (loop_held |-> o_rx_shift_reg_in == $past(i_tx_shift_reg_out))
      else $error("receive input not looped from transmit");
   hs_idle_a: assert property (loop_held |-> o_terminal_ready_n && o_request_to_send_n)
      else $error("handshake outputs active in loopback");
   ext_gate_a: assert property (o_ext_irq |-> $past(i_chan_irq_req))
      else $error("external interrupt without request");
   ms_gate_a: assert property (o_ms_irq_req |-> $past(i_ms_irq_enable))
      else $error("status interrupt while disabled");
   ctrl_top_a: assert property ($past(i_read_strobe) && $past(i_addr) == 3'h4 |-> o_read_data[7:5] == 3'h0)
      else $error("control upper bits read nonzero");
endmodule

/* test/umc_modem_ctrl_tb.sv */
// Self-checking bench for the modem control block.
// Assumes the modem model and the checker are compiled before it.
`timescale 1ns/1ns
module umc_modem_ctrl_tb;
   logic       clk, rst_n, wr_s, rd_s, dab, tx_o, irq_i, ms_en;
   logic [2:0] addr;
   logic [7:0] wdat, rdat;
   logic       clr_n, rdy_n, ring_n, car_n, line, trdy_n, rts_n, serial_out_pin, rxin, xirq, msirq, loop, tick;
   int         n_mismatch = 0, cmp_count = 0, cyc = 0;
   always #25 clk = ~clk;
   umc_modem_partner m (.i_clk(clk), .o_clear_n(clr_n), .o_ready_n(rdy_n), .o_ring_n(ring_n),
      .o_carrier_n(car_n), .o_line(line));
   umc_modem_ctrl i_umc_modem_ctrl (.i_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_write_strobe(wr_s),
      .i_write_data(wdat), .i_read_strobe(rd_s), .i_divisor_access_bit(dab), .i_clear_to_send_n(clr_n),
      .i_data_set_ready_n(rdy_n), .i_ring_in_pin_n(ring_n), .i_carrier_detect_in_n(car_n),
      .i_serial_in_pin(line), .i_tx_shift_reg_out(tx_o), .i_chan_irq_req(irq_i), .i_ms_irq_enable(ms_en),
      .o_read_data(rdat), .o_terminal_ready_n(trdy_n), .o_request_to_send_n(rts_n), .o_serial_out_pin(serial_out_pin),
      .o_rx_shift_reg_in(rxin), .o_ext_irq(xirq), .o_ms_irq_req(msirq), .o_loopback(loop),
      .o_sample_enable(tick));
   // Compare and count
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc_n(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask
   // One-cycle write, returns once the pins have followed
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      #5 {wr_s, addr, wdat} = {1'b1, a, d};
      @(posedge clk);
      #5 wr_s = 0;
      cyc_n(1);
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      #5 {rd_s, addr} = {1'b1, a};
      @(posedge clk);
      #5 d = rdat;
      rd_s = 0;
   endtask
   // Cycles until the next sample pulse
   task automatic gap(output int n);
      n = 0;
      do
      begin
         @(posedge clk);
         #5 n++;
      end
      while (tick !== 1'b1 && n < 400);
   endtask
   task automatic t_ctrl;
      logic [7:0] d;
      rd(3'h4, d);
      chk("ctrl", 8'h00, d);
      chk("pins", 2'h3, {trdy_n, rts_n});
      wr(3'h4, 8'hE1);
      chk("pins", 2'h1, {trdy_n, rts_n});
      wr(3'h4, 8'hE6);
      chk("pins", 2'h2, {trdy_n, rts_n});
      rd(3'h4, d);
      chk("ctrl", 8'h06, d);
      wr(3'h4, 8'h08);
      irq_i = 1;
      cyc_n(2);
      chk("xirq", 1, xirq);
      wr(3'h4, 8'h00);
      chk("xirq", 0, xirq);
      irq_i = 0;
      $display("test control done");
   endtask
   task automatic t_status;
      logic [7:0] d;
      rd(3'h6, d);
      chk("status", 8'h00, d);
      ms_en = 1;
      m.set_pins(4'hE);
      cyc_n(3);
      chk("msirq", 1, msirq);
      rd(3'h6, d);
      chk("status", 8'h11, d);
      rd(3'h6, d);
      chk("status", 8'h10, d);
      chk("msirq", 0, msirq);
      m.set_pins(4'hA);
      cyc_n(3);
      rd(3'h6, d);
      chk("status", 8'h50, d);
      m.set_pins(4'hE);
      cyc_n(3);
      rd(3'h6, d);
      chk("status", 8'h14, d);
      cyc_n(1);
      {rd_s, addr} = {1'b1, 3'h6};
      m.set_pins(4'hC);
      cyc_n(3);
      chk("held", 8'h30, rdat);
      rd_s = 0;
      cyc_n(2);
      rd(3'h6, d);
      chk("status", 8'h32, d);
      m.set_pins(4'hE);
      cyc_n(2);
      {rd_s, addr} = {1'b1, 3'h6};
      m.set_pins(4'hC);
      cyc_n(3);
      rd_s = 0;
      cyc_n(2);
      rd(3'h6, d);
      chk("status", 8'h30, d);
      $display("test status done");
   endtask
   task automatic t_loop;
      logic [7:0] d;
      m.set_pins(4'hF);
      cyc_n(3);
      rd(3'h6, d);
      wr(3'h4, 8'h13);
      cyc_n(2);
      rd(3'h6, d);
      chk("status", 8'h33, d);
      chk("pins", 2'h3, {trdy_n, rts_n});
      m.set_pins(4'h0);
      cyc_n(3);
      rd(3'h6, d);
      chk("status", 8'h30, d);
      wr(3'h4, 8'h1B);
      cyc_n(2);
      rd(3'h6, d);
      chk("status", 8'hB8, d);
      tx_o = 0;
      m.set_line(1);
      cyc_n(2);
      chk("serial", 2'h2, {serial_out_pin, rxin});
      m.set_pins(4'hF);
      wr(3'h4, 8'h00);
      m.set_line(0);
      cyc_n(2);
      chk("serial", 2'h0, {serial_out_pin, rxin});
      tx_o = 1;
      chk("msirq", 1, msirq);
      ms_en = 0;
      cyc_n(2);
      chk("msirq", 0, msirq);
      rd(3'h6, d);
      $display("test loopback done");
   endtask
   task automatic t_baud;
      logic [7:0] d;
      int         n;
      dab = 1;
      wr(3'h0, 8'h03);
      wr(3'h1, 8'h01);
      gap(n);
      gap(n);
      chk("gap", 16'd259, n);
      wr(3'h1, 8'h00);
      gap(n);
      chk("reload", 1, n <= 6);
      gap(n);
      chk("gap", 16'd3, n);
      rd(3'h1, d);
      chk("div_hi", 8'h00, d);
      dab = 0;
      rd(3'h0, d);
      chk("unmapped", 8'h00, d);
      wr(3'h0, 8'h07);
      dab = 1;
      rd(3'h0, d);
      chk("div_lo", 8'h03, d);
      $display("test baud done");
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      {clk, rst_n, wr_s, rd_s, dab, tx_o, irq_i, ms_en} = 8'h04;
      {addr, wdat} = 11'h000;
      repeat (4) @(posedge clk);
      #5 rst_n = 1;
      t_ctrl;
      t_status;
      t_loop;
      t_baud;
      wrap_up;
   end
   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         wrap_up;
      end
   end
endmodule
bind umc_modem_ctrl umc_modem_ctrl_asserts #(.DIV_W(DIV_W)) i_umc_modem_ctrl_asserts (.i_clk(i_clk),
   .i_reset_n(i_reset_n), .i_addr(i_addr), .i_write_strobe(i_write_strobe), .i_write_data(i_write_data),
   .i_read_strobe(i_read_strobe), .i_tx_shift_reg_out(i_tx_shift_reg_out), .i_chan_irq_req(i_chan_irq_req),
   .i_ms_irq_enable(i_ms_irq_enable), .o_read_data(o_read_data), .o_terminal_ready_n(o_terminal_ready_n),
   .o_request_to_send_n(o_request_to_send_n), .o_serial_out_pin(o_serial_out_pin),
   .o_rx_shift_reg_in(o_rx_shift_reg_in), .o_ext_irq(o_ext_irq), .o_ms_irq_req(o_ms_irq_req),
   .o_loopback(o_loopback));

/* test/umc_modem_partner.sv */
// Modem model: drives the four handshake pins and the receive line.
// Assumes the bench calls its tasks; pins change 5 ns after a rising edge.
`timescale 1ns/1ns
module umc_modem_partner (
   input  wire logic i_clk,
   output logic      o_clear_n,
   output logic      o_ready_n,
   output logic      o_ring_n,
   output logic      o_carrier_n,
   output logic      o_line
);
   // Idle: all handshakes inactive, line at mark
   initial {o_carrier_n, o_ring_n, o_ready_n, o_clear_n, o_line} = 5'h1F;
   // Pin levels as {carrier, ring, ready, clear}
   task automatic set_pins(input logic [3:0] v);
      @(posedge i_clk);
      #5 {o_carrier_n, o_ring_n, o_ready_n, o_clear_n} = v;
   endtask
   task automatic set_line(input logic v);
      @(posedge i_clk);
      #5 o_line = v;
   endtask
endmodule
